// ### rtl/tss_pkg.sv
// Constants for the temperature sensor serial slave.
package tss_pkg;
   localparam logic [6:0]  TSS_DEFAULT_ADDR   = 7'h4d;
   localparam logic [7:0]  TSS_CMD_TEMP       = 8'h00;
   localparam logic [7:0]  TSS_CMD_CONFIG     = 8'h01;
   localparam int          TSS_CFG_STBY_BIT   = 7;
   localparam int          TSS_CFG_RDY_BIT    = 6;
   localparam logic [7:0]  TSS_CFG_RESET      = 8'h00;
   localparam logic [7:0]  TSS_TEMP_RESET     = 8'h00;
   localparam int          TSS_CLK_HZ         = 50000000;
   localparam int          TSS_CONV_PERIOD_MS = 125;
   localparam int          TSS_FIRST_READY_MS = 250;
   localparam int          TSS_CONV_CYCLES    = TSS_CLK_HZ / 1000 * TSS_CONV_PERIOD_MS;
   localparam int          TSS_READY_CYCLES   = TSS_CLK_HZ / 1000 * TSS_FIRST_READY_MS;
   localparam int          TSS_BIT_NUM_W      = 4;
   localparam logic [3:0]  TSS_ACK_BIT        = 4'h8;
   typedef enum logic [2:0] {
      TSS_IDLE = 3'b000,
      TSS_ADDR = 3'b001,
      TSS_WCMD = 3'b010,
      TSS_WDAT = 3'b011,
      TSS_RDAT = 3'b100
   } tss_state_type;
endpackage

// ### rtl/tss_slave.sv
// Two-wire temperature sensor slave with standby control and converter timing.
`timescale 1ns/1ps
// Function
// - Answer default seven-bit address 1001101.
// - Respond only to the one configured address.
// - Config bit one selects standby, zero normal.
// - Standby stops converter, freezes result register.
// - Serial port works fully during standby.
// - Completed conversion stored in readable result.
// - Result readable any time without waiting.
// - First valid result ready within 250 ms.
// - Host clock samples and shifts all bits.
// - Data line bidirectional, released when idle.
// - Acknowledge only own address, else silent.
// - Eighth address bit: one read, zero write.
// - Ninth clock: receiver pulls data low.
// - Bytes shifted most significant bit first.
module tss_slave import tss_pkg::*; #(
   parameter logic [6:0] SLAVE_ADDR    = TSS_DEFAULT_ADDR,
   parameter int         CONV_CYCLES   = TSS_CONV_CYCLES,
   parameter int         READY_CYCLES  = TSS_READY_CYCLES
) (
   // Clock and reset.
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_n,
   // Two-wire serial link.
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda,
   output logic            o_sda_oe,
   // Sensing element sample.
   input  wire logic [7:0] i_temp_sample,
   // Status.
   output logic            o_data_ready,
   output logic            o_standby
);
   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers; the second stage and the delayed copy behind it are read.
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic       scl_q_reg;
   logic       sda_q_reg;
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_q_reg    <= 1'b1;
         sda_q_reg    <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], i_scl};
         sda_sync_reg <= {sda_sync_reg[0], i_sda};
         scl_q_reg    <= scl_sync_reg[1];
         sda_q_reg    <= sda_sync_reg[1];
      end
   end

   // Edge and bus condition decode on the settled levels.
   wire scl_now   = scl_sync_reg[1];
   wire sda_now   = sda_sync_reg[1];
   wire scl_rise  = scl_now & ~scl_q_reg;
   wire scl_fall  = ~scl_now & scl_q_reg;
   wire start_det = scl_now & scl_q_reg & sda_q_reg & ~sda_now;
   wire stop_det  = scl_now & scl_q_reg & ~sda_q_reg & sda_now;

   ////////////////////////////////////////////////////////////////////////////////
   // Byte engine state.
   tss_state_type    state_reg;
   tss_state_type    state_next;
   logic [3:0]       bit_reg;
   logic [7:0]       shift_reg;
   logic [7:0]       cmd_reg;
   logic [7:0]       cfg_reg;
   logic [7:0]       temp_reg;
   logic             ack_drive_reg;
   logic             host_nack_reg;
   logic             sda_oe_reg;
   logic             ready_reg;
   logic [31:0]      conv_cnt_reg;

   wire       at_ack     = (bit_reg == TSS_ACK_BIT);
   wire [7:0] shift_in   = {shift_reg[6:0], sda_now};
   wire       addr_match = (shift_reg[7:1] == SLAVE_ADDR);
   wire       addr_read  = shift_reg[0];
   wire       standby    = cfg_reg[TSS_CFG_STBY_BIT];
   wire [7:0] cfg_view   = {standby, ready_reg, 6'h00};
   wire [7:0] read_sel   = (cmd_reg == TSS_CMD_CONFIG) ? cfg_view : temp_reg;
   // A received byte finishes on the falling edge that opens the ack slot.
   wire       byte_done  = scl_fall & (bit_reg == 4'h7);
   wire       ack_done   = scl_fall & at_ack;

   // Next state is taken at the end of each acknowledge clock.
   always_comb begin
      state_next = state_reg;
      if (ack_done) begin
         unique case (state_reg)
            TSS_IDLE: state_next = TSS_IDLE;
            TSS_ADDR: state_next = !ack_drive_reg ? TSS_IDLE :
                                   (addr_read ? TSS_RDAT : TSS_WCMD);
            TSS_WCMD: state_next = TSS_WDAT;
            TSS_WDAT: state_next = TSS_WDAT;
            TSS_RDAT: state_next = host_nack_reg ? TSS_IDLE : TSS_RDAT;
         endcase
      end
   end

   // Bit counter and receive shifter; counts on falling edges of the host clock, shifts on rising edges.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         bit_reg   <= 4'h0;
         shift_reg <= 8'h00;
         state_reg <= TSS_IDLE;
      end else if (start_det) begin
         // The clock fall that closes the start wraps this count to zero, so that
         // fall is not taken for the end of the first address bit.
         bit_reg   <= 4'hf;
         state_reg <= TSS_ADDR;
      end else if (stop_det) begin
         state_reg <= TSS_IDLE;
      end else begin
         state_reg <= state_next;
         if (scl_rise && !at_ack && state_reg != TSS_RDAT) begin
            shift_reg <= shift_in;
         end
         if (scl_fall) begin
            bit_reg <= at_ack ? 4'h0 : bit_reg + 4'h1;
         end
      end
   end

   // Host acknowledge sampled on the ninth rising edge of a read byte.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         host_nack_reg <= 1'b0;
      end else if (scl_rise && at_ack) begin
         host_nack_reg <= sda_now;
      end
   end

   // Acknowledge decision, made as the eighth bit completes.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n || start_det || stop_det) begin
         ack_drive_reg <= 1'b0;
      end else if (byte_done) begin
         ack_drive_reg <= (state_reg == TSS_ADDR) ? addr_match :
                          (state_reg == TSS_WCMD || state_reg == TSS_WDAT);
      end else if (ack_done) begin
         ack_drive_reg <= 1'b0;
      end
   end

   // Command and configuration writes; both work in standby as well.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         cmd_reg <= TSS_CMD_TEMP;
         cfg_reg <= TSS_CFG_RESET;
      end else if (byte_done && state_reg == TSS_WCMD) begin
         cmd_reg <= shift_reg;
      end else if (byte_done && state_reg == TSS_WDAT && cmd_reg == TSS_CMD_CONFIG) begin
         cfg_reg <= {shift_reg[TSS_CFG_STBY_BIT], 7'h00};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit: the line is only ever pulled low, released for a one.
   // Data bits change on falling edges so they are stable while the clock is high.
   logic [7:0] tx_reg;
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n || start_det || stop_det) begin
         sda_oe_reg <= 1'b0;
         tx_reg     <= 8'h00;
      end else if (byte_done) begin
         // Same decision as the acknowledge flag, so an idle slave never answers.
         sda_oe_reg <= (state_reg == TSS_ADDR) ? addr_match :
                       (state_reg == TSS_WCMD || state_reg == TSS_WDAT);
         tx_reg     <= read_sel;
      end else if (ack_done) begin
         if (state_next == TSS_RDAT) begin
            sda_oe_reg <= ~tx_reg[7];
            tx_reg     <= {tx_reg[6:0], 1'b0};
         end else begin
            sda_oe_reg <= 1'b0;
         end
      end else if (scl_fall && state_reg == TSS_RDAT) begin
         sda_oe_reg <= (bit_reg == 4'h7) ? 1'b0 : ~tx_reg[7];
         tx_reg     <= {tx_reg[6:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Converter timing: first result at the ready time, then one per period.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         conv_cnt_reg <= 32'h0;
         ready_reg    <= 1'b0;
         temp_reg     <= TSS_TEMP_RESET;
      end else if (!standby) begin
         if (conv_cnt_reg == 32'(ready_reg ? CONV_CYCLES - 1 : READY_CYCLES - 1)) begin
            conv_cnt_reg <= 32'h0;
            ready_reg    <= 1'b1;
            temp_reg     <= i_temp_sample;
         end else begin
            conv_cnt_reg <= conv_cnt_reg + 32'h1;
         end
      end
   end

   // Registered outputs.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_sda_oe     <= 1'b0;
         o_sda        <= 1'b0;
         o_data_ready <= 1'b0;
         o_standby    <= 1'b0;
      end else begin
         o_sda_oe     <= sda_oe_reg;
         o_sda        <= 1'b0;
         o_data_ready <= ready_reg;
         o_standby    <= standby;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence addr_byte_s;
      byte_done && state_reg == TSS_ADDR;
   endsequence

   ack_own_addr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      addr_byte_s ##1 !start_det && !stop_det |-> sda_oe_reg == $past(addr_match))
      else $error("address acknowledge mismatch");
   stby_freeze_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      standby && $past(standby) |-> $stable(temp_reg) && $stable(conv_cnt_reg))
      else $error("result changed during standby");
   ready_time_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !ready_reg && !standby |-> conv_cnt_reg < 32'(READY_CYCLES))
      else $error("first result late");
   conv_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !standby && conv_cnt_reg == 32'(CONV_CYCLES - 1) && ready_reg
      |=> temp_reg == $past(i_temp_sample))
      else $error("result not loaded");
   stby_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      byte_done && state_reg == TSS_WDAT && cmd_reg == TSS_CMD_CONFIG
      |=> standby == $past(shift_reg[TSS_CFG_STBY_BIT]))
      else $error("standby bit not written");
   resume_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $fell(standby) |=> conv_cnt_reg != $past(conv_cnt_reg))
      else $error("conversions did not resume");
   dir_bit_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ack_done && state_reg == TSS_ADDR && ack_drive_reg && !start_det && !stop_det
      |=> state_reg == (($past(addr_read)) ? TSS_RDAT : TSS_WCMD))
      else $error("direction bit misread");
   idle_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      byte_done && state_reg == TSS_IDLE |=> !sda_oe_reg)
      else $error("acknowledge given while not addressed");
   release_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      state_reg == TSS_IDLE && $past(state_reg) == TSS_IDLE |=> !o_sda_oe)
      else $error("line driven while idle");
endmodule

// ### tb/tss_host.sv
// Behavioural two-wire bus host that drives the sensor slave's link.
`timescale 1ns/1ps
module tss_host (
   // Bus wires.
   output logic      o_scl,
   output logic      o_sda_h,
   input  wire logic i_sda
);
   // The bus idles with both lines high; the clock stands still between frames.
   initial begin
      o_scl   = 1'b1;
      o_sda_h = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One 160 ns bit. The long low phase lets the slave's late release settle first.
   task automatic bit_io(input logic b, output logic r);
      #60 o_sda_h = b;
      #40 o_scl = 1'b1;
      #60 r = i_sda;
      o_scl = 1'b0;
   endtask
   // Start condition, also used as a repeated start.
   task automatic start();
      #40 o_sda_h = 1'b1;
      #40 o_scl = 1'b1;
      #80 o_sda_h = 1'b0;
      #80 o_scl = 1'b0;
   endtask
   // Stop condition; the bus is left idle.
   task automatic stop();
      #40 o_sda_h = 1'b0;
      #40 o_scl = 1'b1;
      #80 o_sda_h = 1'b1;
      #80;
   endtask
   // Eight bits, then the ninth clock with the host's acknowledge or release.
   task automatic xfer(input logic [7:0] d, input logic a_in,
                       output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(a_in, a);
   endtask
endmodule

// ### tb/test_temp_sensor_serial_slave.sv
// Self-checking bench for the temperature sensor serial slave.
`timescale 1ns/1ps
module test_temp_sensor_serial_slave import tss_pkg::*;;
   localparam int RDY  = 200;
   localparam int CONV = 100;
   typedef struct { logic [7:0] sample; logic [7:0] want; } tss_row_type;
   logic       ref_clk;
   logic       rst_n;
   logic [7:0] temp;
   logic       scl;
   logic       sda_h;
   logic       sda_o;
   logic       sda_oe;
   logic       rdy;
   logic       stby;
   logic [7:0] q;
   int         n;
   int         cycles = 0;
   int         bad_count = 0;
   int         samples_checked = 0;
   tss_row_type rows [5] = '{'{8'h19, 8'h19}, '{8'hff, 8'hff}, '{8'h80, 8'h80},
                             '{8'h01, 8'h01}, '{8'h3c, 8'h3c}};
   // Open-drain data wire with a pull-up.
   wire sda_wire = (sda_oe ? sda_o : 1'b1) & sda_h;
   tss_slave #(.CONV_CYCLES(CONV), .READY_CYCLES(RDY)) DUT (
      .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_wire),
      .o_sda(sda_o), .o_sda_oe(sda_oe), .i_temp_sample(temp),
      .o_data_ready(rdy), .o_standby(stby));
   tss_host host (.o_scl(scl), .o_sda_h(sda_h), .i_sda(sda_wire));
   ////////////////////////////////////////////////////////////////////////////////
   // Free-running 50 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // A hang is cut short well beyond the expected run length.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Command write, then a data write or a repeated start and a two-byte read.
   task automatic access(input logic [6:0] adr, input logic [7:0] cmd, input logic rd,
                         input logic [7:0] wd, output logic [7:0] r);
      logic [7:0] x;
      logic       a;
      logic       na;
      na = (adr !== TSS_DEFAULT_ADDR);
      host.start();
      host.xfer({adr, 1'b0}, 1'b1, x, a);
      check({7'h0, a}, {7'h0, na});
      // A refused slave must stay silent for the byte after its address as well.
      host.xfer(cmd, 1'b1, x, a);
      check({7'h0, a}, {7'h0, na});
      if (!na) begin
         if (rd) begin
            host.start();
            host.xfer({adr, 1'b1}, 1'b1, x, a);
            check({7'h0, a}, 8'h00);
            host.xfer(8'hff, 1'b0, r, a);
            host.xfer(8'hff, 1'b1, x, a);
            check(x, r);
         end else begin
            host.xfer(wd, 1'b1, x, a);
            check({7'h0, a}, 8'h00);
         end
      end
      host.stop();
      @(negedge ref_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, table rows, then the awkward cases.
   initial begin
      rst_n = 1'b0;
      temp  = 8'h00;
      repeat (4) @(negedge ref_clk);
      check({6'h0, rdy, stby}, 8'h00);
      rst_n = 1'b1;
      n = 0;
      while (rdy !== 1'b1 && n < RDY + 50) begin
         @(negedge ref_clk);
         n++;
      end
      check({7'h0, rdy & (n <= RDY + 5)}, 8'h01);
      $display("reset test done");
      foreach (rows[k]) begin
         temp = rows[k].sample;
         repeat (CONV + 10) @(negedge ref_clk);
         access(TSS_DEFAULT_ADDR, TSS_CMD_TEMP, 1'b1, 8'h00, q);
         check(q, rows[k].want);
      end
      $display("table test done");
      // Every single-bit neighbour of the address must be ignored.
      for (int b = 0; b < 7; b++) begin
         access(TSS_DEFAULT_ADDR ^ (7'h01 << b), TSS_CMD_TEMP, 1'b1, 8'h00, q);
      end
      $display("address test done");
      access(TSS_DEFAULT_ADDR, TSS_CMD_CONFIG, 1'b0, 8'h80, q);
      check({7'h0, stby}, 8'h01);
      temp = 8'h5a;
      repeat (2 * CONV) @(negedge ref_clk);
      access(TSS_DEFAULT_ADDR, TSS_CMD_TEMP, 1'b1, 8'h00, q);
      check(q, rows[4].want);
      access(TSS_DEFAULT_ADDR, TSS_CMD_CONFIG, 1'b1, 8'h00, q);
      check(q, (8'h01 << TSS_CFG_STBY_BIT) | (8'h01 << TSS_CFG_RDY_BIT));
      access(TSS_DEFAULT_ADDR, TSS_CMD_CONFIG, 1'b0, 8'h00, q);
      check({7'h0, stby}, 8'h00);
      repeat (CONV + 10) @(negedge ref_clk);
      access(TSS_DEFAULT_ADDR, TSS_CMD_TEMP, 1'b1, 8'h00, q);
      check(q, 8'h5a);
      $display("standby test done");
      // A reset in mid-run must clear standby and the ready flag.
      access(TSS_DEFAULT_ADDR, TSS_CMD_CONFIG, 1'b0, 8'h80, q);
      rst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      check({6'h0, rdy, stby}, 8'h00);
      rst_n = 1'b1;
      // After the second release the converter starts over and the link still answers.
      n = 0;
      while (rdy !== 1'b1 && n < RDY + 50) begin
         @(negedge ref_clk);
         n++;
      end
      check({6'h0, rdy & (n <= RDY + 5), stby}, 8'h02);
      access(TSS_DEFAULT_ADDR, TSS_CMD_TEMP, 1'b1, 8'h00, q);
      check(q, 8'h5a);
      $display("second reset test done");
      tally_and_finish();
   end
endmodule
